/* File: design/bmm_memory.sv */
// scratchpad, page store, status/configuration and crc logic of the battery monitor
//
// How it works
// - identity word: family, serial, crc byte
// - crc polynomial x^8 + x^5 + x^4 + 1
// - crc starts zero, lsb first, 56 bits
// - ninth scratchpad byte is its crc
// - crc mismatch never blocks any command
// - eight pages of eight bytes, scratchpad each
// - writes land in scratchpad; copy moves to page
// - status byte bit layout, bit 7 ignored
// - measure enable runs current sampling and counter
// - totals enable keeps totals in page 7
// - shadow bit copies each total increment
// - select bit routes supply or analog input
// - temperature busy while conversion runs
// - nonvolatile busy while copy to storage
// - voltage busy while voltage conversion runs
// - page 0 byte map, only 0,7 writable
// - scratchpad status and threshold govern operation
// - page 1: seconds, counter, offset
// - page 1 byte 7 reads all ones
// - page 2 holds two timestamps
`timescale 1ns/1ps
module bmm_memory
	import bmm_pkg::*;
#(
	parameter int unsigned NV_COPY_CYCLES = NV_COPY_CYC,
	parameter int unsigned VCONV_CYCLES   = VCONV_CYC,
	parameter int unsigned TCONV_CYCLES   = TCONV_CYC,
	parameter int unsigned SAMPLE_CYCLES  = SAMPLE_CYC,
	parameter int unsigned SECOND_CYCLES  = SECOND_CYC
)
(
	// clock and reset
	input  wire logic        mclk_in,
	input  wire logic        rst_in,
	// command port from the bus front end
	input  wire logic        rom_ok_in,
	input  wire bmm_cmd_s    cmd_in,
	output logic             cmd_ready_out,
	output bmm_rsp_s         rsp_out,
	// measurement side
	input  wire bmm_meas_s   meas_in,
	output bmm_ctrl_s        ctrl_out,
	// identity
	output logic [63:0]      id_word_out
);

	typedef enum logic [3:0] {
		ST_IDCRC = 4'b0001,
		ST_IDLE  = 4'b0010,
		ST_CRC   = 4'b0100,
		ST_DONE  = 4'b1000
	} bmm_state_e;

	typedef struct packed {
		bmm_state_e             st;
		logic [2:0]             idx;
		logic [2:0]             page;
		logic                   for_id;
		logic                   ready;
		logic [7:0][7:0][7:0]   sp;
		logic [7:0][7:0][7:0]   mem;
		logic [63:0]            id_word;
		logic [15:0]            chg_tot;
		logic [15:0]            dis_tot;
		logic [31:0]            nv_cnt;
		logic [31:0]            t_cnt;
		logic [31:0]            v_cnt;
		logic [31:0]            smp_cnt;
		logic [31:0]            sec_cnt;
		bmm_rsp_s               rsp;
		bmm_ctrl_s              ctl;
	} bmm_main_s;

	localparam logic [55:0] ID_BODY = {SERIAL_NUMBER, FAMILY_CODE};

	bmm_main_s   s;
	bmm_main_s   n;
	logic        crc_clr;
	logic        crc_vld;
	logic [7:0]  crc_byte;
	logic [7:0]  crc_val;
	logic [7:0]  cfg;
	logic        meas_en;
	logic        tot_en;
	logic        shadow_on;
	logic        cmd_take;
	logic [2:0]  busy3;
	logic [15:0] vres;
	logic [7:0]  cmd_mask;

	// ==========================================================================
	// shared crc engine: identity at start-up, scratchpad on ninth-byte reads
	bmm_crc8 u_crc (
		.mclk_in  (mclk_in),
		.rst_in   (rst_in),
		.clear_in (crc_clr),
		.valid_in (crc_vld),
		.byte_in  (crc_byte),
		.crc_out  (crc_val)
	);

	// ==========================================================================
	// writable bytes of each page; measurement bytes of page 0 are read-only
	function automatic logic [7:0] wr_mask(input logic [2:0] p);
		if (p == PG_STATUS)
			return PAGE0_WR_MASK;
		else if (p == PG_COUNTERS)
			return PAGE1_WR_MASK;
		else
			return FULL_WR_MASK;
	endfunction

	// scratchpad read view with live busy bits and the all-ones reserved byte
	function automatic logic [7:0] sp_view(input logic [2:0] p, input logic [2:0] i);
		logic [7:0] v;
		v = s.sp[p][i];
		if (p == PG_STATUS && i == 3'h0)
			v = {1'b0, busy3, s.sp[p][i][3:0]};
		else if (p == PG_COUNTERS && i == BYTE_LAST)
			v = RSVD_FILL;
		return v;
	endfunction

	// ==========================================================================
	// operation follows the scratchpad copy of status and threshold
	assign cfg       = s.sp[PG_STATUS][0];
	assign meas_en   = cfg[ST_MEAS_EN];
	assign tot_en    = meas_en & cfg[ST_TOT_EN];
	assign shadow_on = tot_en & cfg[ST_SHADOW];
	assign busy3     = {s.ctl.voltage_conv_busy, s.ctl.nonvol_write_busy, s.ctl.temp_busy_flag};
	assign cmd_mask  = wr_mask(cmd_in.page);
	assign vres      = cfg[ST_VSEL] ? meas_in.volt_supply
	                                : meas_in.general_analog_input;
	// commands are not taken until the rom sequence is done; crc results never gate
	assign cmd_take  = (s.st == ST_IDLE) & cmd_in.valid & rom_ok_in;

	// ==========================================================================
	// next-state logic
	always_comb
	begin
		n = s;
		n.rsp.valid = 1'b0;
		n.ctl.current_sample = 1'b0;
		crc_clr = 1'b0;
		crc_vld = 1'b0;
		crc_byte = 8'h00;

		// one-second tick for the elapsed-seconds count
		if (s.sec_cnt == 32'(SECOND_CYCLES - 1))
		begin
			n.sec_cnt = 32'h0;
			n.mem[PG_COUNTERS][3:0] = s.mem[PG_COUNTERS][3:0] + 32'h1;
		end
		else
			n.sec_cnt = s.sec_cnt + 32'h1;

		// current sampling only while measurement is enabled
		if (!meas_en)
			n.smp_cnt = 32'h0;
		else if (s.smp_cnt == 32'(SAMPLE_CYCLES - 1))
		begin
			n.smp_cnt = 32'h0;
			n.mem[PG_STATUS][6:5] = meas_in.current;
			n.ctl.current_sample = 1'b1;
		end
		else
			n.smp_cnt = s.smp_cnt + 32'h1;

		// remaining charge counter and totals; counter floors at zero
		if (meas_en && meas_in.charge_inc)
		begin
			if (s.mem[PG_COUNTERS][4] != ICA_MAX)
				n.mem[PG_COUNTERS][4] = s.mem[PG_COUNTERS][4] + 8'h1;
			if (tot_en)
				n.chg_tot = s.chg_tot + 16'h1;
			if (shadow_on)
				n.mem[PG_TOTALS][5:4] = s.chg_tot + 16'h1;
		end
		if (meas_en && meas_in.discharge_inc)
		begin
			if (s.mem[PG_COUNTERS][4] != 8'h00)
				n.mem[PG_COUNTERS][4] = s.mem[PG_COUNTERS][4] - 8'h1;
			if (tot_en)
				n.dis_tot = s.dis_tot + 16'h1;
			if (shadow_on)
				n.mem[PG_TOTALS][7:6] = s.dis_tot + 16'h1;
		end

		// busy timers; results land in page 0 when a conversion ends
		if (s.ctl.nonvol_write_busy)
		begin
			n.nv_cnt = s.nv_cnt - 32'h1;
			if (s.nv_cnt == 32'h1)
				n.ctl.nonvol_write_busy = 1'b0;
		end
		if (s.ctl.temp_busy_flag)
		begin
			n.t_cnt = s.t_cnt - 32'h1;
			if (s.t_cnt == 32'h1)
			begin
				n.ctl.temp_busy_flag = 1'b0;
				n.mem[PG_STATUS][2:1] = meas_in.temp_result;
			end
		end
		if (s.ctl.voltage_conv_busy)
		begin
			n.v_cnt = s.v_cnt - 32'h1;
			if (s.v_cnt == 32'h1)
			begin
				n.ctl.voltage_conv_busy = 1'b0;
				n.mem[PG_STATUS][4:3] = vres;
			end
		end

		case (s.st)
			ST_IDCRC:
			begin
				// identity crc over family code then serial, lsb first
				crc_vld = 1'b1;
				crc_byte = ID_BODY[{s.idx, 3'b000} +: 8];
				n.idx = s.idx + 3'h1;
				if (s.idx == ID_BYTE_LAST)
					n.st = ST_DONE;
			end
			ST_IDLE:
			begin
				if (cmd_take)
				begin
					n.page = cmd_in.page;
					case (cmd_in.op)
						OP_WRITE_SP:
						begin
							if (!cmd_in.addr[3] && cmd_mask[cmd_in.addr[2:0]])
							begin
								if (cmd_in.page == PG_STATUS && cmd_in.addr[2:0] == 3'h0)
									n.sp[PG_STATUS][0] = cmd_in.data & STATUS_WR_MASK;
								else
									n.sp[cmd_in.page][cmd_in.addr[2:0]] = cmd_in.data;
							end
						end
						OP_READ_SP:
						begin
							if (cmd_in.addr == CRC_BYTE_IDX)
							begin
								crc_clr = 1'b1;
								n.idx = 3'h0;
								n.st = ST_CRC;
							end
							else
							begin
								n.rsp.valid = 1'b1;
								n.rsp.data = sp_view(cmd_in.page, cmd_in.addr[2:0]);
							end
						end
						OP_COPY_SP:
						begin
							// copies that touch storage are refused while storage is busy
							if (cmd_in.page == PG_STAMPS || !s.ctl.nonvol_write_busy)
							begin
								for (int i = 0; i < 8; i++)
									if (cmd_mask[i])
										n.mem[cmd_in.page][i] = s.sp[cmd_in.page][i];
								if (cmd_in.page == PG_TOTALS && tot_en)
								begin
									n.chg_tot = s.sp[PG_TOTALS][5:4];
									n.dis_tot = s.sp[PG_TOTALS][7:6];
								end
								if (cmd_in.page != PG_STAMPS)
								begin
									n.ctl.nonvol_write_busy = 1'b1;
									n.nv_cnt = 32'(NV_COPY_CYCLES);
								end
							end
						end
						OP_RECALL:
						begin
							n.sp[cmd_in.page] = s.mem[cmd_in.page];
							if (cmd_in.page == PG_STATUS)
								n.sp[PG_STATUS][0] = s.mem[PG_STATUS][0] & STATUS_WR_MASK;
							if (cmd_in.page == PG_TOTALS && tot_en)
								n.sp[PG_TOTALS][7:4] = {s.dis_tot, s.chg_tot};
						end
						OP_CONV_T:
						begin
							if (!s.ctl.temp_busy_flag)
							begin
								n.ctl.temp_busy_flag = 1'b1;
								n.t_cnt = 32'(TCONV_CYCLES);
							end
						end
						OP_CONV_V:
						begin
							if (!s.ctl.voltage_conv_busy)
							begin
								n.ctl.voltage_conv_busy = 1'b1;
								n.v_cnt = 32'(VCONV_CYCLES);
							end
						end
						default:
						begin
							n.page = s.page;
						end
					endcase
				end
			end
			ST_CRC:
			begin
				// feed the eight scratchpad bytes, one per cycle, after the ninth-byte read
				crc_vld = 1'b1;
				crc_byte = sp_view(s.page, s.idx);
				n.idx = s.idx + 3'h1;
				if (s.idx == BYTE_LAST)
					n.st = ST_DONE;
			end
			ST_DONE:
			begin
				if (s.for_id)
				begin
					n.id_word = {crc_val, ID_BODY};
					n.for_id = 1'b0;
				end
				else
				begin
					n.rsp.valid = 1'b1;
					n.rsp.data = crc_val;
				end
				n.st = ST_IDLE;
			end
			default:
			begin
				n.st = ST_IDLE;
			end
		endcase

		// outputs follow the scratchpad configuration
		n.ready = (n.st == ST_IDLE);
		n.ctl.current_meas_enable = meas_en;
		n.ctl.totals_enable = tot_en;
		n.ctl.totals_shadow_enable = shadow_on;
		n.ctl.volt_sel = cfg[ST_VSEL];
		n.ctl.threshold = s.sp[PG_STATUS][BYTE_LAST];
	end

	// ==========================================================================
	// state register; status defaults to all features on, reserved byte all ones
	always_ff @(posedge mclk_in)
	begin
		if (rst_in)
		begin
			s <= '0;
			s.st <= ST_IDCRC;
			s.for_id <= 1'b1;
			s.sp[PG_STATUS][0] <= STATUS_RST;
			s.mem[PG_STATUS][0] <= STATUS_RST;
			s.sp[PG_COUNTERS][BYTE_LAST] <= RSVD_FILL;
			s.mem[PG_COUNTERS][BYTE_LAST] <= RSVD_FILL;
		end
		else
			s <= n;
	end

	assign cmd_ready_out = s.ready;
	assign rsp_out       = s.rsp;
	assign ctrl_out      = s.ctl;
	assign id_word_out   = s.id_word;

	// ==========================================================================
	// checks
	a_nvb_copy_start: assert property (@(posedge mclk_in) disable iff (rst_in)
		cmd_take && cmd_in.op == OP_COPY_SP && cmd_in.page != PG_STAMPS
		&& !s.ctl.nonvol_write_busy |=> ctrl_out.nonvol_write_busy)
		else $error("copy to storage did not raise busy");
	a_nvb_hold_min: assert property (@(posedge mclk_in) disable iff (rst_in)
		$rose(ctrl_out.nonvol_write_busy) |-> ctrl_out.nonvol_write_busy [*8])
		else $error("storage busy dropped too early");
	a_rsvd_all_ones: assert property (@(posedge mclk_in) disable iff (rst_in)
		cmd_take && cmd_in.op == OP_READ_SP && cmd_in.page == PG_COUNTERS
		&& cmd_in.addr == 4'h7 |=> rsp_out.valid && rsp_out.data == 8'hFF)
		else $error("reserved byte not all ones");
	a_crc_read_time: assert property (@(posedge mclk_in) disable iff (rst_in)
		cmd_take && cmd_in.op == OP_READ_SP && cmd_in.addr == CRC_BYTE_IDX
		|=> !rsp_out.valid [*8] ##1 !rsp_out.valid ##1 rsp_out.valid)
		else $error("crc byte answer not on the tenth cycle");
	a_rom_gate_idle: assert property (@(posedge mclk_in) disable iff (rst_in)
		s.st == ST_IDLE && cmd_in.valid && !rom_ok_in |=> !rsp_out.valid)
		else $error("command answered before rom sequence");
	a_status_live: assert property (@(posedge mclk_in) disable iff (rst_in)
		cmd_take && cmd_in.op == OP_READ_SP && cmd_in.page == PG_STATUS
		&& cmd_in.addr == 4'h0 |=> rsp_out.data[6:4] == $past(busy3) && !rsp_out.data[7])
		else $error("status byte busy bits wrong");
	a_volt_route: assert property (@(posedge mclk_in) disable iff (rst_in)
		$fell(ctrl_out.voltage_conv_busy) |-> s.mem[PG_STATUS][4:3] == $past(vres))
		else $error("voltage result from wrong input");
	a_meas_off: assert property (@(posedge mclk_in) disable iff (rst_in)
		!meas_en |=> !ctrl_out.current_sample ##1 !ctrl_out.current_sample)
		else $error("current sampled while disabled");
	a_cfg_follow: assert property (@(posedge mclk_in) disable iff (rst_in)
		cfg[ST_TOT_EN] && cfg[ST_MEAS_EN] |=> ctrl_out.totals_enable)
		else $error("totals enable does not follow scratchpad");

endmodule

/* File: pkg/bmm_pkg.sv */
// shared constants, command/answer carriers and timing for the battery monitor memory block
package bmm_pkg;

	// ==========================================================================
	// memory geometry
	localparam int           PAGES          = 8;
	localparam logic [2:0]   PG_STATUS      = 3'h0;
	localparam logic [2:0]   PG_COUNTERS    = 3'h1;
	localparam logic [2:0]   PG_STAMPS      = 3'h2;
	localparam logic [2:0]   PG_TOTALS      = 3'h7;
	localparam logic [2:0]   BYTE_LAST      = 3'h7;
	localparam logic [2:0]   ID_BYTE_LAST   = 3'h6;
	localparam logic [3:0]   CRC_BYTE_IDX   = 4'h8;

	// ==========================================================================
	// status/configuration byte layout and reset value
	localparam int           ST_MEAS_EN     = 0;
	localparam int           ST_TOT_EN      = 1;
	localparam int           ST_SHADOW      = 2;
	localparam int           ST_VSEL        = 3;
	localparam logic [7:0]   STATUS_RST     = 8'h0F;
	localparam logic [7:0]   STATUS_WR_MASK = 8'h0F;
	localparam logic [7:0]   RSVD_FILL      = 8'hFF;
	localparam logic [7:0]   PAGE0_WR_MASK  = 8'h81;
	localparam logic [7:0]   PAGE1_WR_MASK  = 8'h7F;
	localparam logic [7:0]   FULL_WR_MASK   = 8'hFF;
	localparam logic [7:0]   ICA_MAX        = 8'hFF;

	// ==========================================================================
	// crc generator x^8 + x^5 + x^4 + 1, lsb-first (reflected) form
	localparam logic [7:0]   CRC_POLY_REFL  = 8'h8C;
	localparam logic [7:0]   CRC_INIT       = 8'h00;

	// ==========================================================================
	// identity, values arbitrary
	localparam logic [7:0]   FAMILY_CODE    = 8'h5A;
	localparam logic [47:0]  SERIAL_NUMBER  = 48'h0000_1234_5678;

	// ==========================================================================
	// timing
	localparam longint       CLK_HZ         = 50_000_000;
	localparam longint       NV_COPY_MS     = 2;
	localparam longint       VCONV_MS       = 10;
	localparam longint       TCONV_MS       = 10;
	localparam longint       SAMPLE_CHZ     = 3641;
	localparam longint       SECOND_S       = 1;
	localparam int unsigned  NV_COPY_CYC    = int'((NV_COPY_MS * CLK_HZ + 999) / 1000);
	localparam int unsigned  VCONV_CYC      = int'((VCONV_MS * CLK_HZ) / 1000);
	localparam int unsigned  TCONV_CYC      = int'((TCONV_MS * CLK_HZ) / 1000);
	localparam int unsigned  SAMPLE_CYC     = int'((CLK_HZ * 100) / SAMPLE_CHZ);
	localparam int unsigned  SECOND_CYC     = int'(SECOND_S * CLK_HZ);

	// ==========================================================================
	// command port carriers
	typedef enum logic [2:0] {
		OP_WRITE_SP = 3'h0,
		OP_READ_SP  = 3'h1,
		OP_COPY_SP  = 3'h2,
		OP_RECALL   = 3'h3,
		OP_CONV_T   = 3'h4,
		OP_CONV_V   = 3'h5
	} bmm_op_e;

	typedef struct packed {
		logic          valid;
		bmm_op_e       op;
		logic [2:0]    page;
		logic [3:0]    addr;
		logic [7:0]    data;
	} bmm_cmd_s;

	typedef struct packed {
		logic          valid;
		logic [7:0]    data;
	} bmm_rsp_s;

	typedef struct packed {
		logic [15:0]   temp_result;
		logic [15:0]   volt_supply;
		logic [15:0]   general_analog_input;
		logic [15:0]   current;
		logic          charge_inc;
		logic          discharge_inc;
	} bmm_meas_s;

	typedef struct packed {
		logic          current_meas_enable;
		logic          totals_enable;
		logic          totals_shadow_enable;
		logic          volt_sel;
		logic [7:0]    threshold;
		logic          current_sample;
		logic          temp_busy_flag;
		logic          nonvol_write_busy;
		logic          voltage_conv_busy;
	} bmm_ctrl_s;

endpackage

/* File: design/bmm_crc8.sv */
// byte-wide crc-8 accumulator, eight lsb-first shift steps per accepted byte
`timescale 1ns/1ps
module bmm_crc8
	import bmm_pkg::*;
(
	// clock and reset
	input  wire logic        mclk_in,
	input  wire logic        rst_in,
	// byte stream
	input  wire logic        clear_in,
	input  wire logic        valid_in,
	input  wire logic [7:0]  byte_in,
	// result
	output logic      [7:0]  crc_out
);

	typedef struct packed {
		logic [7:0] crc;
	} bmm_crc_s;

	bmm_crc_s s;
	bmm_crc_s s_nxt;

	// ==========================================================================
	// shift each bit in, lsb first; clear wins over a byte in the same cycle
	always_comb
	begin
		logic [7:0] c;
		logic       fb;
		c = s.crc;
		fb = 1'b0;
		for (int i = 0; i < 8; i++)
		begin
			fb = c[0] ^ byte_in[i];
			c = c >> 1;
			if (fb)
				c = c ^ CRC_POLY_REFL;
		end
		s_nxt = s;
		if (clear_in)
			s_nxt.crc = CRC_INIT;
		else if (valid_in)
			s_nxt.crc = c;
	end

	// ==========================================================================
	always_ff @(posedge mclk_in)
	begin
		if (rst_in)
			s <= '{crc: CRC_INIT};
		else
			s <= s_nxt;
	end

	assign crc_out = s.crc;

endmodule

/* File: test/bmm_host.sv */
// host-side model: issues scratchpad commands and computes reference crc values for the bench
`timescale 1ns/1ps
module bmm_host
	import bmm_pkg::*;
(
	// clock
	input  wire logic      mclk_in,
	// answers from the block
	input  wire logic      cmd_ready_in,
	input  wire bmm_rsp_s  rsp_in,
	// requests to the block
	output bmm_cmd_s       cmd_out,
	output logic           rom_ok_out
);
	// idle cycles before each request, nonzero makes a slow host
	int gap = 0;

	initial
	begin
		cmd_out    = '0;
		rom_ok_out = 1'b0;
	end

	// ========================================================================
	// reference crc, x^8 + x^5 + x^4 + 1 shifted lsb first from a zero start
	function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] b);
		logic fb;
		for (int i = 0; i < 8; i++)
		begin
			fb = c[0] ^ b[i];
			c  = c >> 1;
			if (fb)
				c = c ^ 8'h8C;
		end
		return c;
	endfunction

	// ========================================================================
	// rom sequence state: commands mean nothing until it is complete
	task set_rom(input logic v);
		@(posedge mclk_in);
		rom_ok_out <= v;
	endtask

	// one request, driven for a single cycle once ready has been seen high
	task xfer(input bmm_op_e op, input logic [2:0] pg, input logic [3:0] ad,
		input logic [7:0] wd, output logic [7:0] rd, output logic got);
		rd  = 8'h00;
		got = 1'b0;
		repeat (gap + 1) @(posedge mclk_in);
		for (int k = 0; k < 40 && cmd_ready_in !== 1'b1; k++)
			@(posedge mclk_in);
		cmd_out <= '{1'b1, op, pg, ad, wd};
		@(posedge mclk_in);
		cmd_out.valid <= 1'b0;
		// the answer pulse lasts one cycle, so look after every edge
		if (op == OP_READ_SP)
		begin
			for (int k = 0; k < 15; k++)
			begin
				#1;
				if (rsp_in.valid === 1'b1)
				begin
					rd  = rsp_in.data;
					got = 1'b1;
					break;
				end
				@(posedge mclk_in);
			end
		end
	endtask
endmodule

/* File: test/battery_monitor_memory_crc_test.sv */
// self-checking bench for the battery monitor memory and crc block
`timescale 1ns/1ps
module battery_monitor_memory_crc_test;
	import bmm_pkg::*;

	// ========================================================================
	// shortened timer counts
	localparam int NV_N = 20;
	localparam int V_N  = 30;
	localparam int T_N  = 25;

	logic        mclk_in = 1'b0;
	logic        rst_in  = 1'b1;
	bmm_cmd_s    cmd;
	logic        rom_ok;
	logic        ready;
	bmm_rsp_s    rsp;
	bmm_meas_s   meas;
	bmm_ctrl_s   ctrl;
	logic [63:0] id_word;
	logic [2:0]  bv;
	int          fails   = 0;
	int          n_tests = 0;

	assign bv = {ctrl.temp_busy_flag, ctrl.nonvol_write_busy, ctrl.voltage_conv_busy};

	always #10 mclk_in = ~mclk_in;

	bmm_memory #(.NV_COPY_CYCLES(NV_N), .VCONV_CYCLES(V_N), .TCONV_CYCLES(T_N),
		.SAMPLE_CYCLES(16), .SECOND_CYCLES(40)) DUT (
		.mclk_in(mclk_in), .rst_in(rst_in), .rom_ok_in(rom_ok), .cmd_in(cmd),
		.cmd_ready_out(ready), .rsp_out(rsp), .meas_in(meas), .ctrl_out(ctrl),
		.id_word_out(id_word));

	bmm_host host (.mclk_in(mclk_in), .cmd_ready_in(ready), .rsp_in(rsp),
		.cmd_out(cmd), .rom_ok_out(rom_ok));

	// ========================================================================
	// comparison and access helpers
	task chk(input string nm, input logic [63:0] e, input logic [63:0] g);
		n_tests++;
		if (g !== e)
		begin
			$display("Error %s expected %h seen %h", nm, e, g);
			fails++;
		end
	endtask

	task cmd_do(input bmm_op_e op, input logic [2:0] pg, input logic [3:0] ad,
		input logic [7:0] wd);
		logic [7:0] d;
		logic       g;
		host.xfer(op, pg, ad, wd, d, g);
	endtask

	task rd_chk(input logic [2:0] pg, input logic [3:0] ad, input logic [7:0] e);
		logic [7:0] d;
		logic       g;
		host.xfer(OP_READ_SP, pg, ad, 8'h00, d, g);
		chk("read answer", 1'b1, g);
		chk($sformatf("page %0d byte %0d", pg, ad), e, d);
	endtask

	// cycles a busy flag stays high after its command was taken
	task busy_len(input int b, output int n);
		n = 0;
		for (int k = 0; k < 200; k++)
		begin
			#1;
			if (bv[b] === 1'b1)
				n++;
			else if (n > 0)
				break;
			@(posedge mclk_in);
		end
	endtask

	task give_verdict;
		$display("checks %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// ========================================================================
	// watchdog, far beyond the few hundred cycles the tests need
	initial
	begin
		repeat (20000) @(posedge mclk_in);
		fails++;
		$display("Error watchdog expected end seen hang");
		give_verdict;
	end

	// ========================================================================
	// test sequence
	initial
	begin
		logic [7:0] c;
		logic [7:0] w;
		logic [7:0] sv [7];
		int         n;
		sv = '{8'h00, 8'h03, 8'h06, 8'h0D, 8'h07, 8'hFF, 8'h0F};
		meas = '{16'h1234, 16'h0ABC, 16'h0567, 16'hFE80, 1'b0, 1'b0};
		repeat (4) @(posedge mclk_in);
		#1;
		chk("ready in reset", 1'b0, ready);
		rst_in <= 1'b0;
		host.set_rom(1'b1);
		for (int k = 0; k < 20 && ready !== 1'b1; k++)
			@(posedge mclk_in);
		#1;
		c = 8'h00;
		for (int i = 0; i < 7; i++)
			c = host.crc8(c, 8'({SERIAL_NUMBER, FAMILY_CODE} >> (8 * i)));
		chk("identity", {c, SERIAL_NUMBER, FAMILY_CODE}, id_word);
		chk("enable defaults", 4'hF, {ctrl.current_meas_enable, ctrl.totals_enable,
			ctrl.totals_shadow_enable, ctrl.volt_sel});
		rd_chk(3'h0, 4'h0, 8'h0F);
		$display("test done: reset and identity");

		// configuration byte drives the enables, bits above 3 stay clear
		foreach (sv[i])
		begin
			w = sv[i];
			cmd_do(OP_WRITE_SP, 3'h0, 4'h0, w);
			@(posedge mclk_in);
			#1;
			chk("enables", {w[0], w[0] & w[1], w[0] & w[1] & w[2], w[3]},
				{ctrl.current_meas_enable, ctrl.totals_enable,
				ctrl.totals_shadow_enable, ctrl.volt_sel});
			rd_chk(3'h0, 4'h0, w & 8'h0F);
		end
		cmd_do(OP_WRITE_SP, 3'h0, 4'h7, 8'hA5);
		@(posedge mclk_in);
		#1;
		chk("threshold", 8'hA5, ctrl.threshold);
		// store status and threshold so later recalls of page 0 keep them
		cmd_do(OP_COPY_SP, 3'h0, 4'h0, 8'h00);
		busy_len(1, n);
		chk("status copy busy", 1'b1, n >= NV_N && n <= NV_N + 1);
		cmd_do(OP_RECALL, 3'h0, 4'h0, 8'h00);
		cmd_do(OP_WRITE_SP, 3'h0, 4'h5, 8'h00);
		rd_chk(3'h0, 4'h5, 8'h80);
		rd_chk(3'h0, 4'h6, 8'hFE);
		$display("test done: configuration");

		// page 1 reserved byte and counter byte
		cmd_do(OP_WRITE_SP, 3'h1, 4'h7, 8'h00);
		rd_chk(3'h1, 4'h7, 8'hFF);
		cmd_do(OP_WRITE_SP, 3'h1, 4'h4, 8'h33);
		rd_chk(3'h1, 4'h4, 8'h33);
		$display("test done: page 1");

		// scratchpad and crc byte with a slow host, then copy and recall
		host.gap = 3;
		c = 8'h00;
		for (int i = 0; i < 8; i++)
		begin
			cmd_do(OP_WRITE_SP, 3'h3, 4'(i), 8'h3C ^ 8'(i * 17));
			c = host.crc8(c, 8'h3C ^ 8'(i * 17));
		end
		for (int i = 0; i < 8; i++)
			rd_chk(3'h3, 4'(i), 8'h3C ^ 8'(i * 17));
		rd_chk(3'h3, 4'h8, c);
		host.gap = 0;
		cmd_do(OP_COPY_SP, 3'h3, 4'h0, 8'h00);
		rd_chk(3'h0, 4'h0, 8'h2F);
		// a changed byte changes the crc; the read is answered all the same
		cmd_do(OP_WRITE_SP, 3'h3, 4'h2, 8'h00);
		c = 8'h00;
		for (int i = 0; i < 8; i++)
			c = host.crc8(c, (i == 2) ? 8'h00 : 8'h3C ^ 8'(i * 17));
		rd_chk(3'h3, 4'h8, c);
		cmd_do(OP_RECALL, 3'h3, 4'h0, 8'h00);
		rd_chk(3'h3, 4'h2, 8'h3C ^ 8'h22);
		cmd_do(OP_COPY_SP, 3'h4, 4'h0, 8'h00);
		busy_len(1, n);
		chk("copy busy cycles", 1'b1, n >= NV_N && n <= NV_N + 1);
		cmd_do(OP_WRITE_SP, 3'h2, 4'h7, 8'h9E);
		cmd_do(OP_COPY_SP, 3'h2, 4'h0, 8'h00);
		cmd_do(OP_WRITE_SP, 3'h2, 4'h7, 8'h00);
		cmd_do(OP_RECALL, 3'h2, 4'h0, 8'h00);
		rd_chk(3'h2, 4'h7, 8'h9E);
		$display("test done: scratchpad and copy");

		// conversions under both input selections
		for (int s = 1; s >= 0; s--)
		begin
			cmd_do(OP_WRITE_SP, 3'h0, 4'h0, s ? 8'h0F : 8'h07);
			cmd_do(OP_CONV_V, 3'h0, 4'h0, 8'h00);
			busy_len(0, n);
			chk("voltage busy cycles", 1'b1, n >= V_N && n <= V_N + 1);
			cmd_do(OP_RECALL, 3'h0, 4'h0, 8'h00);
			rd_chk(3'h0, 4'h3, s ? 8'hBC : 8'h67);
			rd_chk(3'h0, 4'h4, s ? 8'h0A : 8'h05);
		end
		cmd_do(OP_CONV_T, 3'h0, 4'h0, 8'h00);
		busy_len(2, n);
		chk("temp busy cycles", 1'b1, n >= T_N && n <= T_N + 1);
		cmd_do(OP_RECALL, 3'h0, 4'h0, 8'h00);
		rd_chk(3'h0, 4'h1, 8'h34);
		rd_chk(3'h0, 4'h2, 8'h12);
		$display("test done: conversions");

		// two charge steps then one discharge step move counter and totals
		@(posedge mclk_in);
		meas.charge_inc <= 1'b1;
		repeat (2) @(posedge mclk_in);
		meas.charge_inc    <= 1'b0;
		meas.discharge_inc <= 1'b1;
		@(posedge mclk_in);
		meas.discharge_inc <= 1'b0;
		cmd_do(OP_RECALL, 3'h1, 4'h0, 8'h00);
		rd_chk(3'h1, 4'h4, 8'h01);
		cmd_do(OP_RECALL, 3'h7, 4'h0, 8'h00);
		rd_chk(3'h7, 4'h4, 8'h02);
		// with totals off, page 7 shows the shadowed storage copy
		cmd_do(OP_WRITE_SP, 3'h0, 4'h0, 8'h0D);
		cmd_do(OP_RECALL, 3'h7, 4'h0, 8'h00);
		rd_chk(3'h7, 4'h6, 8'h01);
		$display("test done: counter and totals");

		// without a finished rom sequence commands are ignored
		host.set_rom(1'b0);
		cmd_do(OP_WRITE_SP, 3'h0, 4'h7, 8'h11);
		host.set_rom(1'b1);
		@(posedge mclk_in);
		#1;
		chk("threshold held", 8'hA5, ctrl.threshold);
		rd_chk(3'h0, 4'h7, 8'hA5);
		$display("test done: rom gate");
		give_verdict;
	end
endmodule
